// ==== include/boot_policy_pkg.sv ====
package boot_policy_pkg;

  // ****************************************
  // Configuration word layout
  // ****************************************
  localparam int CFG_MEM_DEPTH = 16;
  localparam int DIG_WORDS = 8;
  localparam logic [3:0] CFG_IDX_POLICY = 4'h0;
  localparam logic [3:0] CFG_IDX_START = 4'h1;
  localparam logic [3:0] CFG_IDX_LEN = 4'h2;
  localparam logic [3:0] CFG_IDX_DIG = 4'h3;
  localparam logic [3:0] CFG_IDX_CRC = 4'hb;
  localparam logic [15:0] MODE_CRC32 = 16'haabb;
  localparam logic [15:0] MODE_SHA256 = 16'hccdd;

  // Generator 0x04c11db7, bit-reversed for the reflected shift
  localparam logic [31:0] CRC_POLY_REFL = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [7:0] SWAP_KEY = 8'hca;
  localparam logic SWAP_HW_RESET = 1'b1;
  localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_CFG_CRC = 2'h1;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CONTROL = 8'h04;
  localparam logic [7:0] ADR_SHADOW = 8'h40;
  localparam logic [7:0] ADR_SHADOW_END = 8'h70;
  localparam int SHADOW_IDX_LSB = 2;
  localparam int SHADOW_IDX_MSB = 5;

  typedef enum logic [3:0] {
    ST_CFG_RD = 4'h0,
    ST_CFG_CHK = 4'h1,
    ST_APPLY = 4'h3,
    ST_SECURE = 4'h2,
    ST_DIG_RD = 4'h6,
    ST_DIG_CHK = 4'h7,
    ST_RUN = 4'h5,
    ST_LOADER = 4'h4,
    ST_SHA_WAIT = 4'hc,
    ST_SHA_CMP = 4'hd,
    ST_FAIL = 4'hf,
    ST_HALT = 4'he,
    ST_DIG_FAIL = 4'ha
  } state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
  } rights_t;

  localparam rights_t RIGHTS_ALL = 3'b111;
  localparam rights_t RIGHTS_EXEC = 3'b101;
  localparam rights_t RIGHTS_DATA = 3'b110;

  typedef struct packed {
    logic [15:0] mode;
    logic [8:0] rsvd;
    logic pin_en;
    logic ldr_en;
    logic quick;
    logic swap;
    logic secure;
    logic hold;
    logic lock;
  } policy_t;

  typedef struct packed {
    logic [22:0] zero;
    logic lock;
    logic dig_bad;
    logic cfg_ok;
    logic [1:0] attempts;
    state_t state;
  } status_t;

  // Bytes go in memory order: low byte first, low bit first
  function automatic logic [31:0] crc32_upd(input logic [31:0] crc, input logic [31:0] data,
                                            input logic [2:0] nbytes);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 32; i++) begin
      if (i < 8 * int'(nbytes)) begin
        c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] bswap32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

endpackage

// ==== design/cfg_shadow_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module cfg_shadow_mem (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_we,
  input wire logic [3:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_raddr_a,
  output logic [31:0] o_rdata_a,
  input wire logic [3:0] i_raddr_b,
  output logic [31:0] o_rdata_b
);
  import boot_policy_pkg::*;

  logic [31:0] mem [CFG_MEM_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata_a <= 32'h0;
      o_rdata_b <= 32'h0;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end

endmodule // cfg_shadow_mem
`default_nettype wire

// ==== design/boot_policy_config_checker.sv ====
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Locked config region: reject program/erase, flag error
// - Secure stage optional; second reset after it
// - Secure stage skips the loader pin sample
// - Write swap setting with its unlock key
// - Swap hardware reset enabled; config default disables
// - After init complete, swap splits bank rights
// - Secure stage grants full rights on all flash
// - Debug hold keeps debug locked until init, only when the secure stage is enabled
// - Quick boot: register/mailbox entry only, no check
// - Mode codes select CRC32 or SHA2-256 check
// - Check covers start address over byte length
// - Failed check: loader if enabled, else fail
// - CRC32 reflected, all-ones start, no inversion
// - CRC32 compares only the first digest word
// - Loader disabled blocks every loader entry
// - Pin entry disabled: pin ignored, software works
// - Config block checked with reflected CRC32
// - Config failure: log, only factory reset/FA go, debug closed
// - Up to three attempts, then wait for reset
module boot_policy_config_checker (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_CFG_RD,
  output logic [3:0] O_CFG_ADDR,
  input wire logic [31:0] I_CFG_DATA,
  output logic O_MAIN_RD,
  output logic [31:0] O_MAIN_ADDR,
  input wire logic [31:0] I_MAIN_DATA,
  output logic O_SHA_START,
  output logic [31:0] O_SHA_ADDR,
  output logic [31:0] O_SHA_LEN,
  input wire logic I_SHA_DONE,
  input wire logic [255:0] I_SHA_DIGEST,
  input wire logic I_FLASH_OP_REQ,
  input wire logic I_FLASH_OP_CFG,
  output logic O_FLASH_OP_OK,
  output logic O_FLASH_OP_ERR,
  input wire logic I_LOADER_PIN,
  input wire logic I_SYSTEM_RESET_LDR_REQ,
  input wire logic I_MBOX_LDR_REQ,
  input wire logic I_INIT_COMPLETE,
  input wire logic I_FACTORY_RST_PEND,
  input wire logic I_FA_PEND,
  output logic O_FACTORY_RST_GO,
  output logic O_FA_GO,
  output logic O_SWAP_WR,
  output logic [7:0] O_SWAP_KEY,
  output logic O_SWAP_POLICY,
  output boot_policy_pkg::rights_t O_LOW_BANK,
  output boot_policy_pkg::rights_t O_HIGH_BANK,
  output logic O_SECURE_RUN,
  output logic O_SYS_RESET,
  output logic O_DEBUG_OPEN,
  output logic O_APP_START,
  output logic O_LOADER_START,
  output logic O_BOOT_FAIL,
  output logic [1:0] O_CFG_FAIL_CAUSE
);
  import boot_policy_pkg::*;

  state_t state;
  policy_t pol;
  logic [31:0] dig_start;
  logic [31:0] dig_len;
  logic [31:0] dig_exp0;
  logic [31:0] crc;
  logic [31:0] crc_stored;
  logic cfg_ok;
  logic [1:0] attempts;
  logic cfg_vld;
  logic [3:0] cfg_vidx;
  logic main_vld;
  logic [31:0] iss_bytes;
  logic [31:0] rem_bytes;
  logic [2:0] nb;
  logic [255:0] sha_dig;
  logic [3:0] sha_idx;
  logic sha_vld;
  logic [2:0] sha_ref;
  logic dig_bad;
  logic init_seen;
  logic ctrl_ldr;
  logic pin_s1;
  logic pin_s2;
  logic pin_ok;
  logic sw_ok;
  logic ldr_go;
  logic dig_on;
  logic lock_on;
  logic in_fail;
  logic wb_req;
  logic wb_p1;
  logic wb_shadow;
  logic [31:0] mem_a;
  logic [31:0] mem_b;
  logic [3:0] sha_raddr;
  logic [31:0] sha_word;
  status_t status;

  // ****************************************
  // Entry gating
  // ****************************************
  // The pin is an asynchronous pad and is only read after the second flop
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= I_LOADER_PIN;
      pin_s2 <= pin_s1;
    end
  end

  always_comb begin
    pin_ok = pol.ldr_en & pol.pin_en & ~pol.secure & ~pol.quick & pin_s2;
    sw_ok = pol.ldr_en & (ctrl_ldr | I_MBOX_LDR_REQ | (I_SYSTEM_RESET_LDR_REQ & ~pol.quick));
    ldr_go = pin_ok | sw_ok;
    dig_on = ~pol.quick & (pol.mode == MODE_CRC32 || pol.mode == MODE_SHA256);
    lock_on = cfg_ok & pol.lock;
    in_fail = (state == ST_FAIL) || (state == ST_HALT);
    nb = (rem_bytes >= 32'(WORD_BYTES)) ? WORD_BYTES : rem_bytes[2:0];
    sha_raddr = CFG_IDX_DIG + sha_idx;
    sha_word = sha_dig[(DIG_WORDS - 1 - int'(sha_ref)) * 32 +: 32];
  end

  // ****************************************
  // Boot sequencer
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= ST_CFG_RD;
      attempts <= 2'h0;
      cfg_ok <= 1'b0;
      crc <= CRC_INIT;
      O_CFG_RD <= 1'b0;
      O_CFG_ADDR <= 4'h0;
      O_MAIN_RD <= 1'b0;
      O_MAIN_ADDR <= 32'h0;
      O_SHA_START <= 1'b0;
      O_SWAP_WR <= 1'b0;
      O_SYS_RESET <= 1'b0;
      O_CFG_FAIL_CAUSE <= CAUSE_NONE;
      iss_bytes <= 32'h0;
      rem_bytes <= 32'h0;
      sha_idx <= 4'h0;
      dig_bad <= 1'b0;
    end else begin
      O_CFG_RD <= 1'b0;
      O_MAIN_RD <= 1'b0;
      O_SHA_START <= 1'b0;
      O_SWAP_WR <= 1'b0;
      O_SYS_RESET <= 1'b0;
      case (state)
        ST_CFG_RD: begin
          if (O_CFG_ADDR != CFG_IDX_CRC || !O_CFG_RD) begin
            O_CFG_RD <= 1'b1;
            O_CFG_ADDR <= O_CFG_RD ? O_CFG_ADDR + 4'h1 : O_CFG_ADDR;
          end
          if (cfg_vld && cfg_vidx != CFG_IDX_CRC) begin
            crc <= crc32_upd(crc, I_CFG_DATA, WORD_BYTES);
          end
          if (cfg_vld && cfg_vidx == CFG_IDX_CRC) begin
            state <= ST_CFG_CHK;
          end
        end
        ST_CFG_CHK: begin
          if (crc == crc_stored) begin
            cfg_ok <= 1'b1;
            O_CFG_FAIL_CAUSE <= CAUSE_NONE;
            state <= ST_APPLY;
          end else begin
            O_CFG_FAIL_CAUSE <= CAUSE_CFG_CRC;
            attempts <= attempts + 2'h1;
            state <= (attempts + 2'h1 == MAX_ATTEMPTS) ? ST_HALT : ST_FAIL;
          end
        end
        ST_FAIL: begin
          // Retry from scratch; a later pass boots normally
          crc <= CRC_INIT;
          O_CFG_ADDR <= CFG_IDX_POLICY;
          state <= ST_CFG_RD;
        end
        ST_HALT: begin
          state <= ST_HALT;
        end
        ST_APPLY: begin
          O_SWAP_WR <= 1'b1;
          if (pol.secure) begin
            state <= ST_SECURE;
          end else if (ldr_go) begin
            state <= ST_LOADER;
          end else if (dig_on) begin
            state <= (pol.mode == MODE_CRC32) ? ST_DIG_RD : ST_SHA_WAIT;
            O_SHA_START <= (pol.mode == MODE_SHA256);
          end else begin
            state <= ST_RUN;
          end
          crc <= CRC_INIT;
          iss_bytes <= 32'h0;
          rem_bytes <= dig_len;
          sha_idx <= 4'h0;
          dig_bad <= 1'b0;
        end
        ST_SECURE: begin
          if (I_INIT_COMPLETE) begin
            O_SYS_RESET <= 1'b1;
            if (ldr_go) begin
              state <= ST_LOADER;
            end else if (dig_on) begin
              state <= (pol.mode == MODE_CRC32) ? ST_DIG_RD : ST_SHA_WAIT;
              O_SHA_START <= (pol.mode == MODE_SHA256);
            end else begin
              state <= ST_RUN;
            end
          end
        end
        ST_DIG_RD: begin
          if (iss_bytes < dig_len) begin
            O_MAIN_RD <= 1'b1;
            O_MAIN_ADDR <= dig_start + iss_bytes;
            iss_bytes <= iss_bytes + 32'(WORD_BYTES);
          end
          if (main_vld) begin
            crc <= crc32_upd(crc, I_MAIN_DATA, nb);
            rem_bytes <= rem_bytes - 32'(nb);
          end
          if (rem_bytes == 32'h0 || (main_vld && rem_bytes == 32'(nb))) begin
            state <= ST_DIG_CHK;
          end
        end
        ST_SHA_WAIT: begin
          if (I_SHA_DONE) begin
            state <= ST_SHA_CMP;
          end
        end
        ST_SHA_CMP: begin
          if (sha_idx != 4'(DIG_WORDS)) begin
            sha_idx <= sha_idx + 4'h1;
          end
          if (sha_vld && mem_b != bswap32(sha_word)) begin
            dig_bad <= 1'b1;
          end
          if (sha_vld && sha_ref == 3'(DIG_WORDS - 1)) begin
            state <= ST_DIG_CHK;
          end
        end
        ST_DIG_CHK: begin
          if ((pol.mode == MODE_CRC32) ? (crc != dig_exp0) : dig_bad) begin
            dig_bad <= 1'b1;
            state <= pol.ldr_en ? ST_LOADER : ST_DIG_FAIL;
          end else begin
            state <= ST_RUN;
          end
        end
        ST_RUN, ST_LOADER, ST_DIG_FAIL: begin
          state <= state;
        end
        default: begin
          state <= ST_CFG_RD;
        end
      endcase
    end
  end

  // ****************************************
  // Data capture pipelines
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cfg_vld <= 1'b0;
      cfg_vidx <= 4'h0;
      main_vld <= 1'b0;
      sha_vld <= 1'b0;
      sha_ref <= 3'h0;
      pol <= '0;
      dig_start <= 32'h0;
      dig_len <= 32'h0;
      dig_exp0 <= 32'h0;
      crc_stored <= 32'h0;
      sha_dig <= '0;
    end else begin
      cfg_vld <= O_CFG_RD;
      cfg_vidx <= O_CFG_ADDR;
      main_vld <= O_MAIN_RD;
      sha_vld <= (state == ST_SHA_CMP) && (sha_idx != 4'(DIG_WORDS));
      sha_ref <= sha_idx[2:0];
      if (I_SHA_DONE && state == ST_SHA_WAIT) begin
        sha_dig <= I_SHA_DIGEST;
      end
      if (cfg_vld) begin
        case (cfg_vidx)
          CFG_IDX_POLICY: pol <= I_CFG_DATA;
          CFG_IDX_START: dig_start <= I_CFG_DATA;
          CFG_IDX_LEN: dig_len <= I_CFG_DATA;
          CFG_IDX_DIG: dig_exp0 <= I_CFG_DATA;
          CFG_IDX_CRC: crc_stored <= I_CFG_DATA;
          default: begin
          end
        endcase
      end
    end
  end

  cfg_shadow_mem u_shadow (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_we(cfg_vld),
    .i_waddr(cfg_vidx),
    .i_wdata(I_CFG_DATA),
    .i_raddr_a(I_WB_ADR[SHADOW_IDX_MSB:SHADOW_IDX_LSB]),
    .o_rdata_a(mem_a),
    .i_raddr_b(sha_raddr),
    .o_rdata_b(mem_b)
  );

  // ****************************************
  // Policy outputs
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SWAP_POLICY <= SWAP_HW_RESET;
      O_SWAP_KEY <= 8'h0;
      O_SHA_ADDR <= 32'h0;
      O_SHA_LEN <= 32'h0;
      init_seen <= 1'b0;
    end else begin
      O_SHA_ADDR <= dig_start;
      O_SHA_LEN <= dig_len;
      if (O_SWAP_WR) begin
        O_SWAP_POLICY <= pol.swap;
        O_SWAP_KEY <= SWAP_KEY;
      end
      if (I_INIT_COMPLETE && cfg_ok) begin
        init_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_LOW_BANK <= RIGHTS_ALL;
      O_HIGH_BANK <= RIGHTS_ALL;
    end else if (state != ST_SECURE && cfg_ok && pol.swap && init_seen) begin
      O_LOW_BANK <= RIGHTS_EXEC;
      O_HIGH_BANK <= RIGHTS_DATA;
    end else begin
      O_LOW_BANK <= RIGHTS_ALL;
      O_HIGH_BANK <= RIGHTS_ALL;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SECURE_RUN <= 1'b0;
      O_DEBUG_OPEN <= 1'b0;
      O_APP_START <= 1'b0;
      O_LOADER_START <= 1'b0;
      O_BOOT_FAIL <= 1'b0;
      O_FACTORY_RST_GO <= 1'b0;
      O_FA_GO <= 1'b0;
    end else begin
      O_SECURE_RUN <= (state == ST_SECURE);
      // Held from policy load, so no open cycle slips in before the secure stage
      O_DEBUG_OPEN <= cfg_ok && !in_fail && !(pol.secure && pol.hold && !init_seen);
      O_APP_START <= (state == ST_RUN);
      O_LOADER_START <= (state == ST_LOADER) && pol.ldr_en;
      O_BOOT_FAIL <= in_fail || (state == ST_DIG_FAIL);
      O_FACTORY_RST_GO <= in_fail && I_FACTORY_RST_PEND;
      O_FA_GO <= in_fail && I_FA_PEND;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FLASH_OP_OK <= 1'b0;
      O_FLASH_OP_ERR <= 1'b0;
    end else begin
      O_FLASH_OP_ERR <= I_FLASH_OP_REQ && I_FLASH_OP_CFG && lock_on;
      O_FLASH_OP_OK <= I_FLASH_OP_REQ && !(I_FLASH_OP_CFG && lock_on);
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Two-edge answer so the shadow memory's registered read is ready
  always_comb begin
    wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK & ~wb_p1;
    wb_shadow = (I_WB_ADR >= ADR_SHADOW) && (I_WB_ADR < ADR_SHADOW_END);
    status = '0;
    status.lock = lock_on;
    status.dig_bad = dig_bad;
    status.cfg_ok = cfg_ok;
    status.attempts = attempts;
    status.state = state;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wb_p1 <= 1'b0;
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
      ctrl_ldr <= 1'b0;
    end else begin
      wb_p1 <= wb_req;
      O_WB_ACK <= wb_p1;
      if (wb_p1) begin
        if (I_WB_WE && I_WB_ADR == ADR_CONTROL && I_WB_SEL[0]) begin
          ctrl_ldr <= I_WB_DAT[0];
        end
        if (wb_shadow) begin
          O_WB_DAT <= mem_a;
        end else if (I_WB_ADR == ADR_STATUS) begin
          O_WB_DAT <= status;
        end else if (I_WB_ADR == ADR_CONTROL) begin
          O_WB_DAT <= {31'h0, ctrl_ldr};
        end else begin
          O_WB_DAT <= 32'h0;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  lock_reject_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (I_FLASH_OP_REQ && I_FLASH_OP_CFG && lock_on) |=> (O_FLASH_OP_ERR && !O_FLASH_OP_OK))
    else $error("locked config write not rejected");
  swap_key_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_SWAP_WR |=> (O_SWAP_KEY == SWAP_KEY && O_SWAP_POLICY == pol.swap))
    else $error("swap policy written without key");
  secure_rights_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (state == ST_SECURE) |=> (O_LOW_BANK == RIGHTS_ALL && O_HIGH_BANK == RIGHTS_ALL))
    else $error("secure stage lacks full rights");
  debug_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (state == ST_SECURE && pol.hold) |=> !O_DEBUG_OPEN)
    else $error("debug opened during held secure stage");
  fail_closed_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    in_fail |=> (!O_APP_START && !O_LOADER_START && !O_DEBUG_OPEN && O_BOOT_FAIL))
    else $error("config failure let something start");
  retry_limit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (state == ST_CFG_CHK && crc != crc_stored) |=>
      (attempts == $past(attempts) + 2'h1) && ((state == ST_HALT) == (attempts == MAX_ATTEMPTS)))
    else $error("wrong retry count");
  quick_skip_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (state == ST_APPLY && pol.quick && !pol.secure) |=> (state != ST_DIG_RD && state != ST_SHA_WAIT))
    else $error("quick boot ran integrity check");
  loader_block_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !pol.ldr_en |=> (!O_LOADER_START && state != ST_LOADER))
    else $error("loader entered while disabled");
  dig_fail_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (state == ST_DIG_CHK && pol.mode == MODE_CRC32 && crc != dig_exp0) |=> (state != ST_RUN))
    else $error("application started after failed check");
  swap_split_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (cfg_ok && pol.swap && init_seen && state == ST_RUN) |=> (O_LOW_BANK == RIGHTS_EXEC))
    else $error("bank rights not split after init");

endmodule // boot_policy_config_checker
`default_nettype wire

// ==== tb/boot_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module boot_partner (
  input wire logic i_clk,
  input wire logic i_cfg_rd,
  input wire logic [3:0] i_cfg_addr,
  output logic [31:0] o_cfg_data,
  input wire logic i_main_rd,
  input wire logic [31:0] i_main_addr,
  output logic [31:0] o_main_data,
  input wire logic i_sha_start,
  output logic o_sha_done,
  output logic [255:0] o_sha_digest,
  input wire logic i_secure_run,
  output logic o_init_complete
);
  logic [31:0] cfg [16];
  // Image covered by the CRC32 check is expected at word 0 of main flash
  logic [31:0] main_mem [16];
  logic [255:0] sha_val;
  int cnt = 0;
  int icnt = 0;
  initial begin
    o_cfg_data = '0;
    o_main_data = '0;
    o_sha_done = 1'b0;
    o_sha_digest = '0;
    o_init_complete = 1'b0;
  end
  // Released lines show the inverse, so a stale word never passes for data
  always @(posedge i_clk) begin
    o_cfg_data <= i_cfg_rd ? cfg[i_cfg_addr] : ~o_cfg_data;
    o_main_data <= i_main_rd ? main_mem[i_main_addr[5:2]] : ~o_main_data;
    o_sha_done <= (cnt == 1);
    o_sha_digest <= (cnt == 1) ? sha_val : ~o_sha_digest;
    cnt <= i_sha_start ? 9 : ((cnt > 0) ? cnt - 1 : 0);
    icnt <= i_secure_run ? icnt + 1 : 0;
    o_init_complete <= (icnt == 20);
  end
endmodule // boot_partner
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import boot_policy_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0, cfg_addr;
  logic [31:0] wdat = '0, rdat, cfg_data, main_addr, main_data, gcrc, sha_addr, sha_len;
  logic ack, cfg_rd, main_rd, sha_start, sha_done, op_ok, op_err, init_c, fr_go, fa_go;
  logic op_req = 1'b0, op_cfg = 1'b0, pin = 1'b0, sys_req = 1'b0, mbox_req = 1'b0;
  logic fr_pend = 1'b0, fa_pend = 1'b0, swap_pol, secure_run, sys_reset, dbg_open, app, ldr;
  logic bfail;
  logic [255:0] sha_dig;
  logic [7:0] swap_key;
  logic [1:0] cause;
  rights_t low_bank, high_bank;
  logic [2:0] prev_out = '0, exp_q[$];
  int err_count = 0, tests_run = 0, cycles = 0;
  localparam logic [31:0] CRC = 32'haabb0000, LD = 32'h20, PIN = 32'h40, QB = 32'h10;

  boot_policy_config_checker DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_CFG_RD(cfg_rd), .O_CFG_ADDR(cfg_addr), .I_CFG_DATA(cfg_data),
    .O_MAIN_RD(main_rd), .O_MAIN_ADDR(main_addr), .I_MAIN_DATA(main_data),
    .O_SHA_START(sha_start), .O_SHA_ADDR(sha_addr), .O_SHA_LEN(sha_len), .I_SHA_DONE(sha_done),
    .I_SHA_DIGEST(sha_dig), .I_FLASH_OP_REQ(op_req), .I_FLASH_OP_CFG(op_cfg),
    .O_FLASH_OP_OK(op_ok), .O_FLASH_OP_ERR(op_err), .I_LOADER_PIN(pin),
    .I_SYSTEM_RESET_LDR_REQ(sys_req), .I_MBOX_LDR_REQ(mbox_req), .I_INIT_COMPLETE(init_c),
    .I_FACTORY_RST_PEND(fr_pend), .I_FA_PEND(fa_pend), .O_FACTORY_RST_GO(fr_go),
    .O_FA_GO(fa_go), .O_SWAP_WR(), .O_SWAP_KEY(swap_key), .O_SWAP_POLICY(swap_pol),
    .O_LOW_BANK(low_bank), .O_HIGH_BANK(high_bank), .O_SECURE_RUN(secure_run),
    .O_SYS_RESET(sys_reset), .O_DEBUG_OPEN(dbg_open), .O_APP_START(app),
    .O_LOADER_START(ldr), .O_BOOT_FAIL(bfail), .O_CFG_FAIL_CAUSE(cause));
  boot_partner p (.i_clk(clk), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .o_cfg_data(cfg_data),
    .i_main_rd(main_rd), .i_main_addr(main_addr), .o_main_data(main_data),
    .i_sha_start(sha_start), .o_sha_done(sha_done), .o_sha_digest(sha_dig),
    .i_secure_run(secure_run), .o_init_complete(init_c));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatched %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Outcome monitor
  // ****************************************
  always @(negedge clk) begin
    prev_out <= {app, ldr, bfail};
    if (({app, ldr, bfail} & ~prev_out) != 3'h0) begin
      chk(32'({app, ldr, bfail}), 32'((exp_q.size() != 0) ? exp_q.pop_front() : 3'h7));
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      c = (c[0] ^ w[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return c;
  endfunction

  task automatic start(input logic [31:0] pol, input logic [2:0] want, input logic good);
    logic [31:0] c;
    c = 32'hffffffff;
    rst_b <= 1'b0;
    p.cfg[0] = pol;
    p.cfg[1] = 32'h100;
    p.cfg[2] = 32'h8;
    for (int i = 0; i < 11; i++) c = crc_step(c, p.cfg[i]);
    gcrc = c;
    p.cfg[11] = good ? c : ~c;
    repeat (3) @(posedge clk);
    chk(32'({swap_pol, low_bank, high_bank}), 32'h7f);
    if (want != 3'h0) exp_q.push_back(want);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  task automatic fin(input int n);
    for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(posedge clk);
    chk(32'(exp_q.size()), 32'h0);
    exp_q.delete();
    $display("test %0d done", n);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] want);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    if (!w) chk(rdat, want);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic op(input logic cfgt, input logic [1:0] want);
    op_req <= 1'b1;
    op_cfg <= cfgt;
    @(posedge clk);
    op_req <= 1'b0;
    @(posedge clk);
    chk(32'({op_ok, op_err}), 32'(want));
    @(posedge clk);
  endtask

  initial begin
    void'($urandom(48));
    for (int i = 4; i < 11; i++) p.cfg[i] = $urandom();
    p.main_mem[0] = 32'h01234567;
    p.main_mem[1] = 32'h89abcdef;
    p.cfg[3] = 32'h24648719;
    p.sha_val = 256'hfdd232547ceee35add35783ca7d518d2a49abccd0b60b028c8a9c629eba6201f;
    start(32'h9, 3'h4, 1'b1);
    fin(1);
    chk(32'({swap_key, swap_pol}), 32'h195);
    op(1'b1, 2'b01);
    op(1'b0, 2'b10);
    start(32'h0, 3'h4, 1'b1);
    fin(2);
    chk(32'(swap_pol), 32'h0);
    op(1'b1, 2'b10);
    start(CRC, 3'h4, 1'b1);
    fin(3);
    wb(1'b0, ADR_SHADOW + 8'h0c, 32'h0, 32'h24648719);
    p.cfg[3] = 32'h24648718;
    start(CRC | LD, 3'h2, 1'b1);
    fin(4);
    start(CRC, 3'h1, 1'b1);
    fin(5);
    pin <= 1'b1;
    start(CRC | LD | QB | PIN, 3'h4, 1'b1);
    fin(6);
    start(CRC | LD | QB, 3'h2, 1'b1);
    wb(1'b1, ADR_CONTROL, 32'h1, 32'h0);
    wb(1'b0, ADR_CONTROL, 32'h0, 32'h1);
    wb(1'b0, 8'hf0, 32'h0, 32'h0);
    fin(7);
    mbox_req <= 1'b1;
    sys_req <= 1'b1;
    start(QB | PIN, 3'h4, 1'b1);
    fin(8);
    mbox_req <= 1'b0;
    sys_req <= 1'b0;
    start(LD, 3'h4, 1'b1);
    fin(9);
    sys_req <= 1'b1;
    start(LD, 3'h2, 1'b1);
    fin(10);
    sys_req <= 1'b0;
    start(32'h6e, 3'h4, 1'b1);
    for (int i = 0; i < 100 && secure_run !== 1'b1; i++) @(posedge clk);
    #1 chk(32'({low_bank, high_bank, dbg_open}), 32'({RIGHTS_ALL, RIGHTS_ALL, 1'b0}));
    for (int i = 0; i < 100 && sys_reset !== 1'b1; i++) @(posedge clk);
    chk(32'(sys_reset), 32'h1);
    fin(11);
    chk(32'({low_bank, high_bank, dbg_open}), 32'({RIGHTS_EXEC, RIGHTS_DATA, 1'b1}));
    for (int i = 0; i < 8; i++) p.cfg[3 + i] = {<<8{p.sha_val[255 - 32 * i -: 32]}};
    start(32'hccdd0000, 3'h4, 1'b1);
    fin(12);
    chk(sha_addr, 32'h100);
    chk(sha_len, 32'h8);
    fr_pend <= 1'b1;
    fa_pend <= 1'b1;
    start(32'h8, 3'h1, 1'b0);
    exp_q.push_back(3'h4);
    for (int i = 0; i < 100 && cause !== 2'h1; i++) @(posedge clk);
    chk(32'({cause, app, ldr, dbg_open}), 32'h08);
    #1 p.cfg[11] = gcrc;
    fin(13);
    start(32'h8, 3'h1, 1'b0);
    exp_q.push_back(3'h1);
    exp_q.push_back(3'h1);
    repeat (300) @(posedge clk);
    chk(32'({app, ldr, dbg_open, swap_key}), 32'h0);
    chk(32'({cause, fr_go, fa_go}), 32'h7);
    fin(14);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
